// file: design/sadc_pkg.sv
`default_nettype none
// ---------------------------------------------------------------------------
// constants and types
// ---------------------------------------------------------------------------
package sadc_pkg;

    localparam int RES_W       = 12;
    localparam int CONV_CLKS   = 66;
    localparam int STEP_CLKS   = 4;
    localparam int SETUP_CLKS  = CONV_CLKS - STEP_CLKS * RES_W;
    localparam int CNT_W       = 7;
    localparam int BIT_W       = 4;
    localparam int CH_W        = 4;
    localparam int CLK_W       = 2;
    localparam int DIV_CNT_W   = 3;
    localparam int REG_W       = 8;
    localparam int DATA_W      = 32;
    localparam int ADDR_W      = 12;
    localparam int IDX_W       = 10;
    localparam int NUM_CH      = 16;

    // register indices, byte address is four times the index
    localparam logic [IDX_W-1:0] IDX_MODE     = 10'h0DD;
    localparam logic [IDX_W-1:0] IDX_RES_HI   = 10'h0DE;
    localparam logic [IDX_W-1:0] IDX_RES_LO   = 10'h0DF;
    localparam logic [IDX_W-1:0] IDX_IRQ_STAT = 10'h0E0;
    localparam logic [IDX_W-1:0] IDX_IRQ_MASK = 10'h0E1;

    // mode register layout
    localparam int MODE_START_BIT = 7;
    localparam int MODE_EOC_BIT   = 6;
    localparam int MODE_CLK_LSB   = 4;
    localparam int MODE_CH_LSB    = 0;
    localparam logic [REG_W-1:0] MODE_RESET = 8'h00;

    // result split
    localparam int RES_HI_W = 8;
    localparam int RES_LO_W = RES_W - RES_HI_W;

    // interrupt status layout
    localparam int IRQ_W          = 2;
    localparam int IRQ_DONE_BIT   = 0;
    localparam int IRQ_REFUSE_BIT = 1;

    localparam logic [CH_W-1:0] CH_UNAVAIL = 4'h3;
    localparam logic [CH_W-1:0] CH_GAP_LO  = 4'h8;
    localparam logic [CH_W-1:0] CH_GAP_HI  = 4'hD;
    localparam logic [CH_W-1:0] CH_BANDGAP = 4'hF;

    typedef enum logic [1:0] {
        SEQ_IDLE,
        SEQ_SETUP,
        SEQ_BITS
    } sadc_seq_state_t;

    function automatic logic sadc_ch_valid(input logic [CH_W-1:0] c);
        return !((c == CH_UNAVAIL) || ((c >= CH_GAP_LO) && (c <= CH_GAP_HI)));
    endfunction

endpackage
`default_nettype wire

// file: design/sadc_conv_if.sv
`timescale 1ns/1ps
`default_nettype none
// ---------------------------------------------------------------------------
// control to sequencer and divider
// ---------------------------------------------------------------------------
interface sadc_conv_if;
    import sadc_pkg::*;

    logic             start;
    logic             abort;
    logic [CLK_W-1:0] clk_sel;
    logic             cmp;
    logic             tick;
    logic             busy;
    logic             done;
    logic [RES_W-1:0] dac_code;
    logic [RES_W-1:0] result;

    modport ctl (output start, output abort, output clk_sel, output cmp,
                 input busy, input done, input dac_code, input result);
    modport div (input clk_sel, input busy, output tick);
    modport seq (input start, input abort, input tick, input cmp,
                 output busy, output done, output dac_code, output result);
endinterface
`default_nettype wire

// file: design/sadc_clk_div.sv
`timescale 1ns/1ps
`default_nettype none
// ---------------------------------------------------------------------------
// conversion clock divider
// ---------------------------------------------------------------------------
module sadc_clk_div
    import sadc_pkg::*;
(
    input  wire logic   sys_clk_i,
    input  wire logic   sys_rst_i,
    sadc_conv_if.div    conv
);
    logic [DIV_CNT_W-1:0] cnt_r;
    logic [DIV_CNT_W-1:0] cnt_nxt;
    logic [DIV_CNT_W-1:0] limit;

    always_comb begin
        limit = DIV_CNT_W'((1 << conv.clk_sel) - 1);
        conv.tick = conv.busy && (cnt_r == limit);
        if (!conv.busy || conv.tick) begin
            cnt_nxt = '0;
        end else begin
            cnt_nxt = DIV_CNT_W'(cnt_r + 1'b1);
        end
    end

    always_ff @(posedge sys_clk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            cnt_r <= '0;
        end else begin
            cnt_r <= cnt_nxt;
        end
    end
endmodule
`default_nettype wire

// file: design/sadc_sar_seq.sv
`timescale 1ns/1ps
`default_nettype none
// ---------------------------------------------------------------------------
// successive approximation sequencer
// ---------------------------------------------------------------------------
module sadc_sar_seq
    import sadc_pkg::*;
(
    input  wire logic   sys_clk_i,
    input  wire logic   sys_rst_i,
    sadc_conv_if.seq    conv
);
    sadc_seq_state_t  state_r,  state_nxt;
    logic [CNT_W-1:0] cnt_r,    cnt_nxt;
    logic [BIT_W-1:0] bit_r,    bit_nxt;
    logic [RES_W-1:0] code_r,   code_nxt;
    logic [RES_W-1:0] result_r, result_nxt;
    logic             done_r,   done_nxt;

    always_comb begin
        state_nxt  = state_r;
        cnt_nxt    = cnt_r;
        bit_nxt    = bit_r;
        code_nxt   = code_r;
        result_nxt = result_r;
        done_nxt   = 1'b0;
        case (state_r)
            SEQ_IDLE: begin
                if (conv.start) begin
                    state_nxt = SEQ_SETUP;
                    cnt_nxt   = '0;
                    code_nxt  = '0;
                end
            end
            SEQ_SETUP: begin
                if (conv.tick) begin
                    if (cnt_r == CNT_W'(SETUP_CLKS - 1)) begin
                        state_nxt = SEQ_BITS;
                        cnt_nxt   = '0;
                        bit_nxt   = BIT_W'(RES_W - 1);
                    end else begin
                        cnt_nxt = CNT_W'(cnt_r + 1'b1);
                    end
                end
            end
            SEQ_BITS: begin
                if (conv.tick) begin
                    if (cnt_r == '0) begin
                        code_nxt[bit_r] = 1'b1;
                    end
                    if (cnt_r == CNT_W'(STEP_CLKS - 1)) begin
                        code_nxt[bit_r] = conv.cmp;
                        cnt_nxt         = '0;
                        if (bit_r == '0) begin
                            state_nxt  = SEQ_IDLE;
                            done_nxt   = 1'b1;
                            result_nxt = code_nxt;
                        end else begin
                            bit_nxt = BIT_W'(bit_r - 1'b1);
                        end
                    end else begin
                        cnt_nxt = CNT_W'(cnt_r + 1'b1);
                    end
                end
            end
            default: begin
                state_nxt = SEQ_IDLE;
            end
        endcase
        if (conv.abort && (state_r != SEQ_IDLE)) begin
            state_nxt = SEQ_IDLE;
            done_nxt  = 1'b0;
        end
    end

    always_ff @(posedge sys_clk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            state_r  <= SEQ_IDLE;
            cnt_r    <= '0;
            bit_r    <= '0;
            code_r   <= '0;
            result_r <= '0;
            done_r   <= 1'b0;
        end else begin
            state_r  <= state_nxt;
            cnt_r    <= cnt_nxt;
            bit_r    <= bit_nxt;
            code_r   <= code_nxt;
            result_r <= result_nxt;
            done_r   <= done_nxt;
        end
    end

    assign conv.busy     = (state_r != SEQ_IDLE);
    assign conv.done     = done_r;
    assign conv.dac_code = code_r;
    assign conv.result   = result_r;
endmodule
`default_nettype wire

// file: design/sadc_mode_ctrl.sv
`timescale 1ns/1ps
`default_nettype none
module sadc_mode_ctrl
    import sadc_pkg::*;
#(
    parameter int SYNC_STAGES = 2
)
(
    input  wire logic              sys_clk_i,
    input  wire logic              sys_rst_i,
    input  wire logic              psel_i,
    input  wire logic              penable_i,
    input  wire logic              pwrite_i,
    input  wire logic [ADDR_W-1:0] paddr_i,
    input  wire logic [DATA_W-1:0] pwdata_i,
    input  wire logic [3:0]        pstrb_i,
    output logic      [DATA_W-1:0] prdata_o,
    output logic                   pready_o,
    output logic                   pslverr_o,
    input  wire logic              cmp_i,
    output logic      [RES_W-1:0]  dac_code_o,
    output logic      [CH_W-1:0]   mux_sel_o,
    output logic      [NUM_CH-1:0] analog_select_o,
    output logic                   bandgap_en_o,
    output logic                   conv_active_o,
    output logic                   irq_o
);
    // -----------------------------------------------------------------------
    // parameter check
    // -----------------------------------------------------------------------
    if (SYNC_STAGES < 2) begin : g_sync_chk
        $error("SYNC_STAGES must be at least 2");
    end

    if ((RES_HI_W + RES_LO_W != RES_W)
            || (STEP_CLKS < 2) || (SETUP_CLKS < 1)
            || (SETUP_CLKS >= (1 << CNT_W))
            || (NUM_CH != (1 << CH_W))) begin : g_pkg_chk
        $error("bad package constants");
    end

    // -----------------------------------------------------------------------
    // state
    // -----------------------------------------------------------------------
    logic                   start_r,     start_nxt;
    logic                   eoc_r,       eoc_nxt;
    logic [CLK_W-1:0]       clk_r,       clk_nxt;
    logic [CH_W-1:0]        ch_r,        ch_nxt;
    logic [CH_W-1:0]        conv_ch_r,   conv_ch_nxt;
    logic [CLK_W-1:0]       conv_clk_r,  conv_clk_nxt;
    logic [RES_HI_W-1:0]    res_hi_r,    res_hi_nxt;
    logic [RES_LO_W-1:0]    res_lo_r,    res_lo_nxt;
    logic [IRQ_W-1:0]       stat_r,      stat_nxt;
    logic [IRQ_W-1:0]       mask_r,      mask_nxt;
    logic                   irq_r,       irq_nxt;
    logic [DATA_W-1:0]      prdata_r,    prdata_nxt;
    logic                   err_r,       err_nxt;
    logic [CH_W-1:0]        mux_r,       mux_nxt;
    logic [NUM_CH-1:0]      asel_r,      asel_nxt;
    logic                   bgap_r,      bgap_nxt;
    logic [SYNC_STAGES-1:0] sync_r;

    logic                   setup_ph;
    logic                   access_ph;
    logic                   addr_err;
    logic [IDX_W-1:0]       idx;
    logic                   wr_en;
    logic                   wr_mode;
    logic                   wr_stat;
    logic                   wr_mask;
    logic [CH_W-1:0]        wr_ch;
    logic [CLK_W-1:0]       wr_clk;
    logic                   start_pulse;
    logic                   abort_pulse;
    logic                   refuse_pulse;
    logic [IRQ_W-1:0]       events;
    logic [CH_W-1:0]        act_ch;
    logic [REG_W-1:0]       mode_val;

    sadc_conv_if conv ();

    // -----------------------------------------------------------------------
    // submodules
    // -----------------------------------------------------------------------
    sadc_clk_div u_div (
        .sys_clk_i (sys_clk_i),
        .sys_rst_i (sys_rst_i),
        .conv      (conv)
    );

    sadc_sar_seq u_seq (
        .sys_clk_i (sys_clk_i),
        .sys_rst_i (sys_rst_i),
        .conv      (conv)
    );

    // -----------------------------------------------------------------------
    // comparator synchroniser
    // -----------------------------------------------------------------------
    always_ff @(posedge sys_clk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            sync_r <= '0;
        end else begin
            sync_r <= {sync_r[SYNC_STAGES-2:0], cmp_i};
        end
    end

    assign conv.cmp     = sync_r[SYNC_STAGES-1];
    assign conv.clk_sel = conv_clk_r;
    assign conv.start   = start_pulse;
    assign conv.abort   = abort_pulse;

    // -----------------------------------------------------------------------
    // apb decode
    // -----------------------------------------------------------------------
    always_comb begin
        setup_ph  = psel_i && !penable_i;
        access_ph = psel_i && penable_i;
        idx       = paddr_i[ADDR_W-1:2];
        addr_err  = (paddr_i[1:0] != 2'b00)
                 || !((idx == IDX_MODE)     || (idx == IDX_RES_HI)
                   || (idx == IDX_RES_LO)   || (idx == IDX_IRQ_STAT)
                   || (idx == IDX_IRQ_MASK));
        wr_en     = access_ph && pwrite_i && !err_r && pstrb_i[0];
        wr_mode   = wr_en && (idx == IDX_MODE);
        wr_stat   = wr_en && (idx == IDX_IRQ_STAT);
        wr_mask   = wr_en && (idx == IDX_IRQ_MASK);
        wr_ch     = pwdata_i[MODE_CH_LSB +: CH_W];
        wr_clk    = pwdata_i[MODE_CLK_LSB +: CLK_W];
    end

    always_comb begin
        mode_val                          = '0;
        mode_val[MODE_START_BIT]          = start_r;
        mode_val[MODE_EOC_BIT]            = eoc_r;
        mode_val[MODE_CLK_LSB +: CLK_W]   = clk_r;
        mode_val[MODE_CH_LSB +: CH_W]     = ch_r;
        prdata_nxt = prdata_r;
        err_nxt    = err_r;
        if (setup_ph) begin
            err_nxt    = addr_err;
            prdata_nxt = '0;
            if (!addr_err && !pwrite_i) begin
                case (idx)
                    IDX_MODE:     prdata_nxt[REG_W-1:0]    = mode_val;
                    IDX_RES_HI:   prdata_nxt[RES_HI_W-1:0] = res_hi_r;
                    IDX_RES_LO: begin
                        prdata_nxt[RES_LO_W-1:0] = res_lo_r;
                    end
                    IDX_IRQ_STAT: prdata_nxt[IRQ_W-1:0]    = stat_r;
                    IDX_IRQ_MASK: prdata_nxt[IRQ_W-1:0]    = mask_r;
                    default:      prdata_nxt               = '0;
                endcase
            end
        end
    end

    // -----------------------------------------------------------------------
    // mode and result registers
    // -----------------------------------------------------------------------
    always_comb begin
        start_nxt    = start_r;
        eoc_nxt      = eoc_r;
        clk_nxt      = clk_r;
        ch_nxt       = ch_r;
        conv_ch_nxt  = conv_ch_r;
        conv_clk_nxt = conv_clk_r;
        res_hi_nxt   = res_hi_r;
        res_lo_nxt   = res_lo_r;
        start_pulse  = 1'b0;
        abort_pulse  = 1'b0;
        refuse_pulse = 1'b0;
        if (wr_mode) begin
            clk_nxt = wr_clk;
            ch_nxt  = wr_ch;
            if (pwdata_i[MODE_START_BIT]) begin
                if (!conv.busy) begin
                    if (sadc_ch_valid(wr_ch)) begin
                        start_pulse  = 1'b1;
                        start_nxt    = 1'b1;
                        eoc_nxt      = 1'b0;
                        conv_ch_nxt  = wr_ch;
                        conv_clk_nxt = wr_clk;
                    end else begin
                        refuse_pulse = 1'b1;
                        start_nxt    = 1'b0;
                    end
                end
            end else begin
                start_nxt   = 1'b0;
                abort_pulse = conv.busy;
            end
        end
        if (conv.done) begin
            res_hi_nxt = conv.result[RES_W-1 -: RES_HI_W];
            res_lo_nxt = conv.result[RES_LO_W-1:0];
            if (!start_pulse) begin
                eoc_nxt   = 1'b1;
                start_nxt = 1'b0;
            end
        end
    end

    // -----------------------------------------------------------------------
    // interrupt
    // -----------------------------------------------------------------------
    always_comb begin
        events                 = '0;
        events[IRQ_DONE_BIT]   = conv.done;
        events[IRQ_REFUSE_BIT] = refuse_pulse;
        stat_nxt = stat_r;
        if (wr_stat) begin
            stat_nxt = stat_r & ~pwdata_i[IRQ_W-1:0];
        end
        stat_nxt = stat_nxt | events;
        mask_nxt = wr_mask ? pwdata_i[IRQ_W-1:0] : mask_r;
        irq_nxt  = |(stat_nxt & mask_nxt);
    end

    // -----------------------------------------------------------------------
    // channel routing
    // -----------------------------------------------------------------------
    always_comb begin
        act_ch   = conv.busy ? conv_ch_r : ch_r;
        mux_nxt  = act_ch;
        bgap_nxt = (act_ch == CH_BANDGAP);
    end

    for (genvar i = 0; i < NUM_CH; i++) begin : g_asel
        assign asel_nxt[i] = (i != int'(CH_BANDGAP))
                          && sadc_ch_valid(act_ch)
                          && (act_ch == CH_W'(i));
    end

    // -----------------------------------------------------------------------
    // registers
    // -----------------------------------------------------------------------
    always_ff @(posedge sys_clk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            start_r    <= MODE_RESET[MODE_START_BIT];
            eoc_r      <= MODE_RESET[MODE_EOC_BIT];
            clk_r      <= MODE_RESET[MODE_CLK_LSB +: CLK_W];
            ch_r       <= MODE_RESET[MODE_CH_LSB +: CH_W];
            conv_ch_r  <= '0;
            conv_clk_r <= '0;
            res_hi_r   <= '0;
            res_lo_r   <= '0;
            stat_r     <= '0;
            mask_r     <= '0;
            irq_r      <= 1'b0;
            prdata_r   <= '0;
            err_r      <= 1'b0;
            mux_r      <= '0;
            asel_r     <= '0;
            bgap_r     <= 1'b0;
        end else begin
            start_r    <= start_nxt;
            eoc_r      <= eoc_nxt;
            clk_r      <= clk_nxt;
            ch_r       <= ch_nxt;
            conv_ch_r  <= conv_ch_nxt;
            conv_clk_r <= conv_clk_nxt;
            res_hi_r   <= res_hi_nxt;
            res_lo_r   <= res_lo_nxt;
            stat_r     <= stat_nxt;
            mask_r     <= mask_nxt;
            irq_r      <= irq_nxt;
            prdata_r   <= prdata_nxt;
            err_r      <= err_nxt;
            mux_r      <= mux_nxt;
            asel_r     <= asel_nxt;
            bgap_r     <= bgap_nxt;
        end
    end

    // -----------------------------------------------------------------------
    // outputs
    // -----------------------------------------------------------------------
    assign prdata_o        = prdata_r;
    assign pready_o        = access_ph;
    assign pslverr_o       = access_ph && err_r;
    assign dac_code_o      = conv.dac_code;
    assign mux_sel_o       = mux_r;
    assign analog_select_o = asel_r;
    assign bandgap_en_o    = bgap_r;
    assign conv_active_o   = conv.busy;
    assign irq_o           = irq_r;
endmodule
`default_nettype wire

// file: test/sadc_mode_ctrl_props.sv
`timescale 1ns/1ps
`default_nettype none
// ---------------------------------------------------------------------------
// port checker
// ---------------------------------------------------------------------------
module sadc_mode_ctrl_props
    import sadc_pkg::*;
(
    input  wire logic              sys_clk_i,
    input  wire logic              sys_rst_i,
    input  wire logic              psel_i,
    input  wire logic              penable_i,
    input  wire logic              pwrite_i,
    input  wire logic [ADDR_W-1:0] paddr_i,
    input  wire logic [DATA_W-1:0] pwdata_i,
    input  wire logic [3:0]        pstrb_i,
    input  wire logic [CH_W-1:0]   mux_sel_o,
    input  wire logic [NUM_CH-1:0] analog_select_o,
    input  wire logic              bandgap_en_o,
    input  wire logic              conv_active_o
);
    default clocking cb @(posedge sys_clk_i); endclocking
    default disable iff (sys_rst_i);
    localparam logic [ADDR_W-1:0] A_MODE = {IDX_MODE, 2'b00};
    logic       wr;
    logic       okw;
    logic       okm;
    logic       ws;
    logic       ab_r;
    logic       ab_nxt;
    logic [9:0] cnt_r;
    logic [9:0] cnt_nxt;
    assign wr  = psel_i && penable_i && pwrite_i && paddr_i == A_MODE
                 && pstrb_i[0];
    assign okw = !(pwdata_i[3:0] == 4'h3 || pwdata_i[3:0] inside {[8:13]});
    assign okm = !(mux_sel_o == 4'h3 || mux_sel_o inside {[8:13]});
    assign ws  = wr && pwdata_i[7];
    always_comb begin
        cnt_nxt = conv_active_o ? cnt_r + 10'h001 : 10'h000;
        ab_nxt  = (wr && !pwdata_i[7] && conv_active_o) ? 1'b1
                  : (conv_active_o ? ab_r : 1'b0);
    end
    always_ff @(posedge sys_clk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            cnt_r <= 10'h000;
            ab_r  <= 1'b0;
        end else begin
            cnt_r <= cnt_nxt;
            ab_r  <= ab_nxt;
        end
    end
    a_go_start: assert property (wr && pwdata_i[7] && !conv_active_o && okw
        |-> ##[1:2] conv_active_o) else $error("start not taken");
    a_stop_abort: assert property (wr && !pwdata_i[7] && conv_active_o
        |-> ##[1:3] !conv_active_o) else $error("stop not taken");
    a_no_spur: assert property ($rose(conv_active_o) |->
        $past(ws) || $past(ws, 2))
        else $error("start without write");
    a_conv_len: assert property ($fell(conv_active_o) && !ab_r |->
        cnt_r >= 10'd66 && cnt_r <= 10'd532)
        else $error("conversion length wrong");
    a_sel_onehot: assert property ($onehot0(analog_select_o))
        else $error("several pins selected");
    a_bg_excl: assert property (bandgap_en_o |-> analog_select_o == 16'h0000)
        else $error("bandgap with pin");
    a_sel_match: assert property (!conv_active_o && !$past(conv_active_o)
        && analog_select_o != 16'h0000 |->
        analog_select_o == (16'h0001 << mux_sel_o))
        else $error("pin select differs from channel");
    a_gap_none: assert property (!conv_active_o && !$past(conv_active_o)
        && !okm |-> !bandgap_en_o && analog_select_o == 16'h0000)
        else $error("unavailable code selects");
    a_bg_code: assert property (!conv_active_o && !$past(conv_active_o)
        && bandgap_en_o |-> mux_sel_o == 4'hF)
        else $error("bandgap on wrong code");
    c_done: cover property ($fell(conv_active_o) && !ab_r);
    c_abort: cover property ($fell(conv_active_o) && ab_r);
    c_bg: cover property (bandgap_en_o && conv_active_o);
endmodule
`default_nettype wire

// file: test/sadc_afe_model.sv
`timescale 1ns/1ps
`default_nettype none
// ---------------------------------------------------------------------------
// analog mux and comparator
// ---------------------------------------------------------------------------
module sadc_afe_model
    import sadc_pkg::*;
#(
    parameter logic [RES_W-1:0] BG_LVL = 12'h555
)
(
    input  wire logic [RES_W-1:0] ain_i,
    input  wire logic [RES_W-1:0] dac_code_i,
    input  wire logic             bandgap_en_i,
    output logic                  cmp_o
);
    logic [RES_W-1:0] lvl;
    assign lvl   = bandgap_en_i ? BG_LVL : ain_i;
    assign cmp_o = (lvl >= dac_code_i);
endmodule
`default_nettype wire

// file: test/tb_top.sv
`timescale 1ns/1ps
`default_nettype none
module tb_top;
    import sadc_pkg::*;
    localparam logic [ADDR_W-1:0] A_MODE = {IDX_MODE, 2'b00};
    localparam logic [ADDR_W-1:0] A_HI   = {IDX_RES_HI, 2'b00};
    localparam logic [ADDR_W-1:0] A_LO   = {IDX_RES_LO, 2'b00};
    localparam logic [ADDR_W-1:0] A_ST   = {IDX_IRQ_STAT, 2'b00};
    localparam logic [ADDR_W-1:0] A_MK   = {IDX_IRQ_MASK, 2'b00};
    logic              sys_clk, sys_rst, psel, penable, pwrite, cmp;
    logic              pready, pslverr, bg, act, irq, er;
    logic [ADDR_W-1:0] paddr;
    logic [DATA_W-1:0] pwdata, prdata, rd;
    logic [3:0]        pstrb, mux;
    logic [RES_W-1:0]  dac, ain;
    logic [NUM_CH-1:0] asel;
    int                n_errors, checks, n;
    sadc_mode_ctrl u_sadc_mode_ctrl (.sys_clk_i(sys_clk), .sys_rst_i(sys_rst),
        .psel_i(psel), .penable_i(penable), .pwrite_i(pwrite),
        .paddr_i(paddr), .pwdata_i(pwdata), .pstrb_i(pstrb),
        .prdata_o(prdata), .pready_o(pready), .pslverr_o(pslverr),
        .cmp_i(cmp), .dac_code_o(dac), .mux_sel_o(mux),
        .analog_select_o(asel), .bandgap_en_o(bg), .conv_active_o(act),
        .irq_o(irq));
    sadc_afe_model u_sadc_afe_model (.ain_i(ain), .dac_code_i(dac),
        .bandgap_en_i(bg), .cmp_o(cmp));
    initial begin
        sys_clk = 1'b0;
        forever #12.5 sys_clk = ~sys_clk;
    end
    task automatic chk(input string nm, input logic [31:0] s, e);
        checks++;
        if (s !== e) begin
            n_errors++;
            $display("ERROR %s exp %h seen %h", nm, e, s);
        end
    endtask
    task automatic apb(input logic w, input logic [ADDR_W-1:0] a,
                       input logic [7:0] d);
        @(posedge sys_clk);
        psel   <= 1'b1;
        pwrite <= w;
        paddr  <= a;
        pwdata <= 32'(d);
        @(posedge sys_clk);
        penable <= 1'b1;
        @(posedge sys_clk);
        while (pready !== 1'b1) @(posedge sys_clk);
        rd = prdata;
        er = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
    endtask
    task automatic conv(input logic [1:0] s, input logic [3:0] c);
        apb(1'b1, A_MODE, {2'b10, s, c});
        n = 0;
        while ((act !== 1'b0 || n < 3) && n < 700) begin
            @(posedge sys_clk);
            n++;
        end
    endtask
    task automatic finish_test;
        $display("checks %0d n_errors %0d", checks, n_errors);
        if (n_errors == 0 && checks > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask
    task automatic t_reset;
        apb(1'b0, A_MODE, 8'h00);
        chk("mode", rd, 32'h00);
        apb(1'b0, A_MK, 8'h00);
        chk("mask", rd, 32'h00);
        apb(1'b0, 12'h3F0, 8'h00);
        chk("unmapped", 32'(er), 32'h1);
        $display("test reset done");
    endtask
    task automatic t_clk;
        for (int s = 0; s < 4; s++) begin
            ain = 12'h9A3 + 12'(s * 273);
            conv(s[1:0], 4'h1);
            chk("len", 32'(n >= (66 << s) - 2 &&
                           n <= (66 << s) + 4), 1);
            apb(1'b0, A_MODE, 8'h00);
            chk("mode", rd, 32'(8'h41 | (s << 4)));
            apb(1'b0, A_HI, 8'h00);
            chk("hi", rd, 32'(ain[11:4]));
            apb(1'b0, A_LO, 8'h00);
            chk("lo", rd, 32'(ain[3:0]));
            apb(1'b1, A_MODE, 8'(8'h01 | (s << 4)));
            apb(1'b0, A_MODE, 8'h00);
            chk("eoc ro", rd, 32'(8'h41 | (s << 4)));
        end
        $display("test clock select done");
    endtask
    task automatic t_chan;
        logic ok;
        for (int c = 0; c < 16; c++) begin
            ok = !(c == 3 || (c >= 8 && c <= 13));
            apb(1'b1, A_MODE, 8'(8'h80 | c));
            repeat (2) @(posedge sys_clk);
            chk("asel", 32'(asel),
                (ok && c != 15) ? 32'h1 << c : 0);
            chk("bg", 32'(bg), 32'(c == 15));
            if (!ok) begin
                apb(1'b0, A_MODE, 8'h00);
                chk("start", 32'(rd[7]), 32'h0);
                apb(1'b0, A_ST, 8'h00);
                chk("refuse", 32'(rd[1]), 32'h1);
                apb(1'b1, A_ST, 8'h02);
            end else begin
                while (act !== 1'b0) @(posedge sys_clk);
            end
        end
        $display("test channels done");
    endtask
    task automatic t_busy;
        apb(1'b1, A_MODE, 8'h92);
        apb(1'b0, A_MODE, 8'h00);
        chk("eoc clr", 32'(rd[6]), 32'h0);
        apb(1'b1, A_MODE, 8'h94);
        repeat (2) @(posedge sys_clk);
        chk("mux", 32'(mux), 32'h2);
        apb(1'b1, A_MODE, 8'h14);
        repeat (3) @(posedge sys_clk);
        chk("act", 32'(act), 32'h0);
        apb(1'b0, A_MODE, 8'h00);
        chk("mode", rd, 32'h14);
        $display("test busy and stop done");
    endtask
    task automatic t_irq;
        apb(1'b1, A_ST, 8'h03);
        apb(1'b1, A_MK, 8'h01);
        conv(2'b00, 4'h2);
        repeat (2) @(posedge sys_clk);
        chk("irq", 32'(irq), 32'h1);
        apb(1'b1, A_ST, 8'h01);
        repeat (2) @(posedge sys_clk);
        chk("irq clr", 32'(irq), 32'h0);
        apb(1'b1, A_MK, 8'h00);
        conv(2'b00, 4'h2);
        chk("irq mask", 32'(irq), 32'h0);
        apb(1'b0, A_ST, 8'h00);
        chk("done", 32'(rd[0]), 32'h1);
        $display("test interrupt done");
    endtask
    initial begin
        #500000;
        n_errors++;
        finish_test();
    end
    initial begin
        sys_rst = 1'b1;
        {psel, penable, pwrite} = 3'b000;
        paddr  = '0;
        pwdata = '0;
        pstrb  = 4'hF;
        ain    = 12'h800;
        repeat (6) @(posedge sys_clk);
        sys_rst <= 1'b0;
        t_reset();
        t_clk();
        t_chan();
        t_busy();
        t_irq();
        finish_test();
    end
endmodule
bind sadc_mode_ctrl sadc_mode_ctrl_props u_props (.sys_clk_i(sys_clk_i),
    .sys_rst_i(sys_rst_i), .psel_i(psel_i), .penable_i(penable_i),
    .pwrite_i(pwrite_i), .paddr_i(paddr_i), .pwdata_i(pwdata_i),
    .pstrb_i(pstrb_i), .mux_sel_o(mux_sel_o),
    .analog_select_o(analog_select_o), .bandgap_en_o(bandgap_en_o),
    .conv_active_o(conv_active_o));
`default_nettype wire
